// file: rtl/pilc_top.sv
// Interrupt controller top: request latches, enables, fixed priority and vectors.
// Assumes the CPU core drives the SFR port, the enable flags and the acceptance pulse
// synchronously to ref_clk_i, and that the watchdog supplies its output select bit.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Thirty-nine slots; trap and watchdog pseudo non-maskable.
// - Each maskable source has latch and vector.
// - Offer needs master and source enable flags.
// - Simultaneous requests served in fixed slot priority.
// - Among non-maskable sources the trap (slot 1) beats the watchdog (slot 2).
// - Fixed vector per source, descending addresses.
// - Software and undefined traps have no latch.
// - Latch clears when CPU accepts its interrupt.
// - All latches zero during reset.
// - Latches mapped at five byte SFR offsets.
// - Software clears single latches independently.
// - Reading latch register returns pending states.
// - Instruction writes never set a latch.
// - Watchdog resets unless output select cleared.
// - Written zero clears, written one leaves latch.
// - Acceptance saves and clears master flag; return sets.
// - Pseudo non-maskable requests ignore enable flags.
module pilc_top #(
    parameter int unsigned NUM_SLOTS = pilc_pkg::NUM_SLOTS
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // SFR access port from the CPU core.
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_rd_i,
    output logic [7:0] sfr_rdata_o,
    // Enable flags and master flag control from the CPU core.
    input wire logic [38:0] source_enable_flag_i,
    input wire logic ext_irq_zero_pin_enable_i,
    input wire logic ei_i,
    input wire logic di_i,
    input wire logic maskable_return_instr_i,
    // Hardware request pulses, one bit per slot; bits 0 to 2 are unused here.
    input wire logic [38:0] src_req_i,
    // Software trap and undefined-instruction trap requests, held until accepted.
    input wire logic software_trap_i,
    // Watchdog request pulse and its output select bit.
    input wire logic watchdog_irq_i,
    input wire logic watchdog_output_select_i,
    // Interrupt offer to the CPU core and its acceptance pulse.
    output logic irq_valid_o,
    output logic [5:0] irq_slot_o,
    output logic [19:0] irq_vector_o,
    input wire logic irq_ack_i,
    // Master flag state and its saved copy.
    output logic master_enable_flag_o,
    output logic saved_imf_o,
    // Watchdog reset request pulse.
    output logic wdt_reset_o
);

    // The slot map and SFR layout are fixed at 39 slots.
    if (NUM_SLOTS != 39) begin : g_bad_slots
        $error("pilc_top supports exactly 39 priority slots");
    end

    // Vector address of a slot; slots 32 and above sit in a separate block.
    function automatic logic [19:0] slot_vector(input logic [5:0] slot);
        logic [19:0] offs;
        offs = 20'h00000;
        if (slot == pilc_pkg::SLOT_RESET) begin
            slot_vector = pilc_pkg::VEC_RESET;
        end else if (slot == pilc_pkg::SLOT_SWTRAP) begin
            slot_vector = pilc_pkg::VEC_SWTRAP;
        end else if (slot == pilc_pkg::SLOT_WDT) begin
            slot_vector = pilc_pkg::VEC_WDT;
        end else if (slot < pilc_pkg::SLOT_HIGH_BASE) begin
            offs = 20'(slot - pilc_pkg::SLOT_FIRST_MASK) * pilc_pkg::VEC_STEP;
            slot_vector = pilc_pkg::VEC_LOW_BASE - offs;
        end else begin
            offs = 20'(slot - pilc_pkg::SLOT_HIGH_BASE) * pilc_pkg::VEC_STEP;
            slot_vector = pilc_pkg::VEC_HIGH_BASE - offs;
        end
    endfunction

    pilc_pkg::pilc_state_t st_r;
    pilc_pkg::pilc_state_t st_nxt;
    pilc_pkg::pilc_offer_t offer;
    logic [38:0] set_vec;
    logic [38:0] clr_vec;
    logic [38:0] cand;
    logic [38:0] enable_eff;

    // Latch set requests; the watchdog only lands in its latch while the output select bit is zero.
    always_comb begin
        set_vec = src_req_i;
        set_vec[0] = 1'b0;
        set_vec[1] = 1'b0;
        set_vec[2] = watchdog_irq_i & ~watchdog_output_select_i;
    end

    // Latch clears from software writes of zero and from acceptance.
    always_comb begin
        clr_vec = '0;
        if (sfr_wr_i) begin
            unique case (sfr_addr_i)
                pilc_pkg::OFS_LATCH_LOW: begin
                    clr_vec[pilc_pkg::BASE_LOW +: 8] = ~sfr_wdata_i;
                end
                pilc_pkg::OFS_LATCH_HIGH: begin
                    clr_vec[pilc_pkg::BASE_HIGH +: 8] = ~sfr_wdata_i;
                end
                pilc_pkg::OFS_LATCH_BANK_E: begin
                    clr_vec[pilc_pkg::BASE_BANK_E +: 8] = ~sfr_wdata_i;
                end
                pilc_pkg::OFS_LATCH_BANK_D: begin
                    clr_vec[pilc_pkg::BASE_BANK_D +: 8] = ~sfr_wdata_i;
                end
                pilc_pkg::OFS_LATCH_BANK_C: begin
                    clr_vec[pilc_pkg::BASE_BANK_C +: 7] = ~sfr_wdata_i[6:0];
                end
                default: begin
                    clr_vec = '0;
                end
            endcase
        end
        // Acceptance clears the latch of the slot then on offer.
        if (irq_ack_i && st_r.offer_valid) begin
            clr_vec[st_r.offer_slot] = 1'b1;
        end
    end

    // Effective enables: master flag, per-source flag, pin enable for external zero.
    always_comb begin
        enable_eff = {39{st_nxt.master_enable_flag}} & source_enable_flag_i;
        enable_eff[3] = enable_eff[3] & ext_irq_zero_pin_enable_i;
        enable_eff[2:0] = 3'h7;
    end

    // Candidate requests to offer; the software trap comes straight from the CPU.
    always_comb begin
        cand = st_nxt.latch & enable_eff;
        cand[0] = 1'b0;
        cand[1] = software_trap_i & ~irq_ack_i;
    end

    // Fixed priority pick: the lowest slot number wins.
    always_comb begin
        offer.valid = |cand;
        offer.slot = pilc_pkg::SLOT_LAST;
        for (int i = 38; i >= 0; i--) begin
            if (cand[i]) begin
                offer.slot = 6'(i);
            end
        end
        offer.vector = slot_vector(offer.slot);
    end

    // Next-state computation for every register of the controller except the offer fields.
    always_comb begin
        st_nxt = st_r;
        // Set wins over clear so no request is lost to a concurrent clear.
        st_nxt.latch = (st_r.latch & ~clr_vec) | set_vec;
        st_nxt.latch[1:0] = 2'b00;
        // Master flag: instructions first, acceptance last so it always clears.
        if (ei_i || maskable_return_instr_i) begin
            st_nxt.master_enable_flag = 1'b1;
        end
        if (di_i) begin
            st_nxt.master_enable_flag = 1'b0;
        end
        if (irq_ack_i && st_r.offer_valid) begin
            st_nxt.saved_imf = st_r.master_enable_flag;
            st_nxt.master_enable_flag = 1'b0;
        end
        // Watchdog request becomes a reset request while the select bit is one.
        st_nxt.wdt_reset = watchdog_irq_i & watchdog_output_select_i;
        // Read data is captured one cycle after the read strobe.
        st_nxt.rdata = pilc_pkg::RDATA_RST;
        if (sfr_rd_i) begin
            unique case (sfr_addr_i)
                pilc_pkg::OFS_LATCH_LOW: begin
                    st_nxt.rdata = st_r.latch[pilc_pkg::BASE_LOW +: 8];
                end
                pilc_pkg::OFS_LATCH_HIGH: begin
                    st_nxt.rdata = st_r.latch[pilc_pkg::BASE_HIGH +: 8];
                end
                pilc_pkg::OFS_LATCH_BANK_E: begin
                    st_nxt.rdata = st_r.latch[pilc_pkg::BASE_BANK_E +: 8];
                end
                pilc_pkg::OFS_LATCH_BANK_D: begin
                    st_nxt.rdata = st_r.latch[pilc_pkg::BASE_BANK_D +: 8];
                end
                pilc_pkg::OFS_LATCH_BANK_C: begin
                    st_nxt.rdata = {1'b0, st_r.latch[pilc_pkg::BASE_BANK_C +: 7]};
                end
                default: begin
                    st_nxt.rdata = pilc_pkg::RDATA_RST;
                end
            endcase
        end
    end

    // Offer fields are taken from the next state so they track it without lag.
    pilc_pkg::pilc_state_t st_reg_in;
    always_comb begin
        st_reg_in = st_nxt;
        st_reg_in.offer_valid = offer.valid;
        st_reg_in.offer_slot = offer.slot;
        st_reg_in.offer_vec = offer.vector;
    end

    // State register; reset clears every latch and the master flag.
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r.latch <= pilc_pkg::LATCH_RST;
            st_r.master_enable_flag <= 1'b0;
            st_r.saved_imf <= 1'b0;
            st_r.offer_valid <= 1'b0;
            st_r.offer_slot <= pilc_pkg::SLOT_RESET;
            st_r.offer_vec <= pilc_pkg::VEC_RESET;
            st_r.rdata <= pilc_pkg::RDATA_RST;
            st_r.wdt_reset <= 1'b0;
        end else begin
            st_r <= st_reg_in;
        end
    end

    // Outputs come straight from the state register.
    assign sfr_rdata_o = st_r.rdata;
    assign irq_valid_o = st_r.offer_valid;
    assign irq_slot_o = st_r.offer_slot;
    assign irq_vector_o = st_r.offer_vec;
    assign master_enable_flag_o = st_r.master_enable_flag;
    assign saved_imf_o = st_r.saved_imf;
    assign wdt_reset_o = st_r.wdt_reset;

endmodule
`default_nettype wire

// file: include/pilc_pkg.sv
// Package for the prioritized interrupt latch controller.
// Holds SFR offsets, slot numbers, vector addresses and the state carrier.
// Assumes an 8-bit SFR access port and a 20-bit CPU vector space.
`default_nettype none
package pilc_pkg;

    // Widths of the SFR port and of vector addresses.
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned VEC_W = 20;
    localparam int unsigned SLOT_W = 6;

    // Slot numbering: slot equals the fixed priority, 0 being highest.
    localparam int unsigned NUM_SLOTS = 39;
    localparam logic [5:0] SLOT_RESET = 6'h00;
    localparam logic [5:0] SLOT_SWTRAP = 6'h01;
    localparam logic [5:0] SLOT_WDT = 6'h02;
    localparam logic [5:0] SLOT_EXT0 = 6'h03;
    localparam logic [5:0] SLOT_FIRST_MASK = 6'h03;
    localparam logic [5:0] SLOT_LAST_LOW = 6'h1F;
    localparam logic [5:0] SLOT_HIGH_BASE = 6'h20;
    localparam logic [5:0] SLOT_LAST = 6'h26;

    // SFR offsets of the request latch registers.
    localparam logic [7:0] OFS_LATCH_LOW = 8'h3C;
    localparam logic [7:0] OFS_LATCH_HIGH = 8'h3D;
    localparam logic [7:0] OFS_LATCH_BANK_E = 8'h2E;
    localparam logic [7:0] OFS_LATCH_BANK_D = 8'h2F;
    localparam logic [7:0] OFS_LATCH_BANK_C = 8'h2B;

    // First latch slot held by each register; bank C holds slots 32 to 38.
    localparam int unsigned BASE_LOW = 0;
    localparam int unsigned BASE_HIGH = 8;
    localparam int unsigned BASE_BANK_E = 16;
    localparam int unsigned BASE_BANK_D = 24;
    localparam int unsigned BASE_BANK_C = 32;

    // Fixed vector addresses.
    localparam logic [19:0] VEC_RESET = 20'hFFFFC;
    localparam logic [19:0] VEC_SWTRAP = 20'hFFFF8;
    localparam logic [19:0] VEC_WDT = 20'hFFFF4;
    localparam logic [19:0] VEC_LOW_BASE = 20'hFFFF0;
    localparam logic [19:0] VEC_HIGH_BASE = 20'hFFF3C;
    localparam logic [19:0] VEC_STEP = 20'h00004;

    // Reset values.
    localparam logic [38:0] LATCH_RST = 39'h00_0000_0000;
    localparam logic [7:0] RDATA_RST = 8'h00;

    // All state of the controller, registered as one word.
    typedef struct packed {
        logic [38:0] latch;
        logic master_enable_flag;
        logic saved_imf;
        logic offer_valid;
        logic [5:0] offer_slot;
        logic [19:0] offer_vec;
        logic [7:0] rdata;
        logic wdt_reset;
    } pilc_state_t;

    // Request presented to the CPU core.
    typedef struct packed {
        logic valid;
        logic [5:0] slot;
        logic [19:0] vector;
    } pilc_offer_t;

endpackage
`default_nettype wire

// file: verification/pilc_sva.sv
// Checker for the interrupt latch controller, watching only its top ports.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module pilc_sva #(
    parameter int unsigned NUM_SLOTS = 39
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // Register reads and flag controls.
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic di_i,
    input wire logic maskable_return_instr_i,
    // Request sources.
    input wire logic software_trap_i,
    input wire logic watchdog_irq_i,
    input wire logic watchdog_output_select_i,
    // Offer, acceptance and flags.
    input wire logic irq_valid_o,
    input wire logic [5:0] irq_slot_o,
    input wire logic [19:0] irq_vector_o,
    input wire logic irq_ack_i,
    input wire logic master_enable_flag_o,
    input wire logic saved_imf_o,
    input wire logic wdt_reset_o
);
    // All checks share the controller clock and reset.
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    // Vector expected for the offered slot; a second, separate descending run starts at slot 32.
    logic [19:0] vec_exp;
    assign vec_exp = (irq_slot_o < 6'h20 ? 20'hFFFFC : 20'hFFFBC) - {12'h000, irq_slot_o, 2'h0};
    chk_read_idle: assert property (!sfr_rd_i |=> sfr_rdata_o == 8'h00)
        else $error("read data not idle");
    chk_vector_map: assert property (irq_valid_o |-> irq_vector_o == vec_exp)
        else $error("offered vector wrong");
    chk_mask_gate: assert property (irq_valid_o && irq_slot_o > 6'h02 |-> master_enable_flag_o)
        else $error("maskable offer with master flag clear");
    chk_accept_save: assert property (irq_ack_i && irq_valid_o |=> !master_enable_flag_o && saved_imf_o == $past(master_enable_flag_o))
        else $error("acceptance did not save and clear master flag");
    chk_return_set: assert property (maskable_return_instr_i && !di_i && !(irq_ack_i && irq_valid_o) |=> master_enable_flag_o)
        else $error("return did not set master flag");
    chk_trap_offer: assert property (software_trap_i && !irq_ack_i |=> irq_valid_o && irq_slot_o == 6'h01)
        else $error("trap not offered");
    chk_wdt_pulse: assert property (watchdog_irq_i && watchdog_output_select_i |=> wdt_reset_o ##1 !wdt_reset_o)
        else $error("watchdog reset pulse wrong");
    chk_wdt_cause: assert property (wdt_reset_o |-> $past(watchdog_irq_i) && $past(watchdog_output_select_i))
        else $error("watchdog reset without cause");
    chk_accept_clear: assert property (irq_ack_i && irq_valid_o && irq_slot_o == 6'h02 && !watchdog_irq_i |=> !(irq_valid_o && irq_slot_o == 6'h02))
        else $error("accepted latch still offered");
    chk_disable_clear: assert property (di_i |=> !master_enable_flag_o)
        else $error("disable did not clear master flag");
    cover property (irq_ack_i && irq_valid_o && irq_slot_o > 6'h02);
    cover property (wdt_reset_o);
    cover property (irq_valid_o && irq_slot_o == 6'h01);
endmodule
bind pilc_top pilc_sva #(.NUM_SLOTS(NUM_SLOTS)) u_sva (.ref_clk_i, .rst_b_i, .sfr_rd_i,
    .sfr_rdata_o, .di_i, .maskable_return_instr_i, .software_trap_i, .watchdog_irq_i,
    .watchdog_output_select_i, .irq_valid_o, .irq_slot_o, .irq_vector_o, .irq_ack_i,
    .master_enable_flag_o, .saved_imf_o, .wdt_reset_o);
`default_nettype wire

// file: verification/pilc_cpu_model.sv
// CPU core stand-in: accepts offers after a chosen delay and raises the software trap.
// Assumes the controller offer is registered on the same clock.
`timescale 1ns/1ps
`default_nettype none
module pilc_cpu_model (
    // Clock, reset and bench control.
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic en_i,
    input wire logic [3:0] dly_i,
    input wire logic trap_go_i,
    // Controller side.
    input wire logic irq_valid_i,
    input wire logic [5:0] irq_slot_i,
    input wire logic [19:0] irq_vector_i,
    output logic irq_ack_o,
    output logic software_trap_o,
    // Record of the last acceptance.
    output logic [5:0] acc_slot_o,
    output logic [19:0] acc_vec_o,
    output logic [7:0] acc_cnt_o
);
    logic [3:0] wait_r;
    // One acceptance pulse per offer; the trap is held until it is taken.
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_ack_o <= 1'b0;
            software_trap_o <= 1'b0;
            wait_r <= 4'h0;
            acc_slot_o <= 6'h00;
            acc_vec_o <= 20'h00000;
            acc_cnt_o <= 8'h00;
        end else if (irq_ack_o) begin
            irq_ack_o <= 1'b0;
            acc_slot_o <= irq_slot_i;
            acc_vec_o <= irq_vector_i;
            acc_cnt_o <= acc_cnt_o + 8'h01;
            wait_r <= 4'h0;
            if (irq_slot_i == 6'h01) software_trap_o <= 1'b0;
        end else begin
            if (trap_go_i) software_trap_o <= 1'b1;
            if (en_i && irq_valid_i && wait_r == dly_i) irq_ack_o <= 1'b1;
            else if (en_i && irq_valid_i) wait_r <= wait_r + 4'h1;
        end
    end
endmodule
`default_nettype wire

// file: verification/pilc_bench.sv
// Self-checking bench for the interrupt latch controller with a CPU stand-in.
// Assumes the controller and CPU model share one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module pilc_bench;
    logic ref_clk_i = 1'b0, rst_b_i = 1'b0, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, ei_i = 1'b0;
    logic di_i = 1'b0, maskable_return_instr_i = 1'b0, ext_irq_zero_pin_enable_i = 1'b0;
    logic watchdog_irq_i = 1'b0, watchdog_output_select_i = 1'b1, en = 1'b0, trap_go = 1'b0;
    logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o, bitv, acc_cnt;
    logic [38:0] source_enable_flag_i = '0, src_req_i = '0;
    logic [3:0] dly = 4'h3;
    logic [5:0] irq_slot_o, acc_slot;
    logic [19:0] irq_vector_o, acc_vec;
    logic irq_valid_o, irq_ack_i, software_trap_i, master_enable_flag_o, saved_imf_o, wdt_reset_o;
    logic [7:0] regs [5] = '{8'h3C, 8'h3D, 8'h2E, 8'h2F, 8'h2B};
    logic [5:0] slots [5] = '{6'h06, 6'h0C, 6'h10, 6'h18, 6'h26};
    int bad_count = 0, total_checks = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    pilc_top u_dut (.ref_clk_i, .rst_b_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rd_i,
        .sfr_rdata_o, .source_enable_flag_i, .ext_irq_zero_pin_enable_i, .ei_i, .di_i,
        .maskable_return_instr_i, .src_req_i, .software_trap_i, .watchdog_irq_i,
        .watchdog_output_select_i, .irq_valid_o, .irq_slot_o, .irq_vector_o, .irq_ack_i,
        .master_enable_flag_o, .saved_imf_o, .wdt_reset_o);
    pilc_cpu_model u_cpu (.ref_clk_i, .rst_b_i, .en_i(en), .dly_i(dly), .trap_go_i(trap_go),
        .irq_valid_i(irq_valid_o), .irq_slot_i(irq_slot_o), .irq_vector_i(irq_vector_o),
        .irq_ack_o(irq_ack_i), .software_trap_o(software_trap_i), .acc_slot_o(acc_slot),
        .acc_vec_o(acc_vec), .acc_cnt_o(acc_cnt));
    // Compares one value and counts the result.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // One-cycle register write.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        sfr_addr_i <= a;
        sfr_wdata_i <= d;
        sfr_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        sfr_wr_i <= 1'b0;
    endtask
    // One-cycle register read; data is registered and shows after the strobe edge.
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge ref_clk_i);
        sfr_addr_i <= a;
        sfr_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        sfr_rd_i <= 1'b0;
        #1 check(what, sfr_rdata_o, exp);
        // Return on a rising edge so that the next stimulus lands on the edge.
        @(posedge ref_clk_i);
    endtask
    // One-cycle hardware request pulse.
    task automatic pulse(input logic [38:0] v);
        @(posedge ref_clk_i);
        src_req_i <= v;
        @(posedge ref_clk_i);
        src_req_i <= '0;
    endtask
    // Waits a bounded time for the n-th acceptance and checks what was taken.
    task automatic take(input logic [7:0] n, input logic [5:0] s, input logic [19:0] v);
        for (int i = 0; i < 40 && acc_cnt !== n; i++) @(posedge ref_clk_i);
        if (acc_cnt !== n) begin
            bad_count++;
            $display("[ERR] acceptance count expected %h seen %h", n, acc_cnt);
            stop_test();
        end
        check("accepted slot", acc_slot, s);
        check("accepted vector", acc_vec, v);
    endtask
    // Main sequence: latch map, priority and masking, then the non-maskable sources.
    initial begin
        repeat (10) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        rd_reg(8'h3A, 8'h00, "unmapped read");
        for (int k = 0; k < 5; k++) begin
            bitv = 8'h01 << slots[k][2:0];
            rd_reg(regs[k], 8'h00, "reset latch");
            wr_reg(regs[k], 8'hFF);
            rd_reg(regs[k], 8'h00, "write of ones");
            pulse(39'h1 << slots[k]);
            rd_reg(regs[k], bitv, "latched request");
            wr_reg(regs[k], 8'hFF);
            rd_reg(regs[k], bitv, "ones kept");
            wr_reg(regs[k], ~bitv);
            rd_reg(regs[k], 8'h00, "cleared latch");
        end
        $display("test latch map done");
        source_enable_flag_i <= {39{1'b1}};
        en <= 1'b1;
        pulse((39'h1 << 38) | (39'h1 << 6));
        repeat (3) @(posedge ref_clk_i);
        #1 check("masked offer", irq_valid_o, 1'b0);
        @(posedge ref_clk_i);
        ei_i <= 1'b1;
        @(posedge ref_clk_i);
        ei_i <= 1'b0;
        take(8'h01, 6'h06, 20'hFFFE4);
        #1 check("flags after accept", {master_enable_flag_o, saved_imf_o}, 2'h1);
        rd_reg(8'h3C, 8'h00, "accepted latch");
        maskable_return_instr_i <= 1'b1;
        @(posedge ref_clk_i);
        maskable_return_instr_i <= 1'b0;
        take(8'h02, 6'h26, 20'hFFF24);
        dly <= 4'h0;
        pulse(39'h1 << 3);
        ei_i <= 1'b1;
        @(posedge ref_clk_i);
        ei_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        #1 check("pin gated offer", irq_valid_o, 1'b0);
        @(posedge ref_clk_i);
        di_i <= 1'b1;
        @(posedge ref_clk_i);
        di_i <= 1'b0;
        ext_irq_zero_pin_enable_i <= 1'b1;
        #1 check("master after disable", master_enable_flag_o, 1'b0);
        @(posedge ref_clk_i);
        #1 check("offer while disabled", irq_valid_o, 1'b0);
        @(posedge ref_clk_i);
        ei_i <= 1'b1;
        @(posedge ref_clk_i);
        ei_i <= 1'b0;
        take(8'h03, 6'h03, 20'hFFFF0);
        $display("test priority and masking done");
        watchdog_irq_i <= 1'b1;
        @(posedge ref_clk_i);
        watchdog_irq_i <= 1'b0;
        #1 check("watchdog reset", wdt_reset_o, 1'b1);
        rd_reg(8'h3C, 8'h00, "watchdog latch idle");
        watchdog_output_select_i <= 1'b0;
        watchdog_irq_i <= 1'b1;
        trap_go <= 1'b1;
        @(posedge ref_clk_i);
        watchdog_irq_i <= 1'b0;
        trap_go <= 1'b0;
        take(8'h04, 6'h01, 20'hFFFF8);
        take(8'h05, 6'h02, 20'hFFFF4);
        rd_reg(8'h3C, 8'h00, "watchdog latch cleared");
        $display("test non-maskable sources done");
        stop_test();
    end
endmodule
`default_nettype wire
